// *** hw/laser_drive_fault_control.sv ***
// Purpose: laser drive mode selection, hold-off after reset, fault shutdown and self-test
// Assumes: register port from the serial decoder on clk; fault pins are asynchronous
// Notes:   a fault latches until the next reset
`timescale 1ns/100ps
module laser_drive_fault_control
  import laser_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // register port
  input  wire reg_req_t   req,
  output logic [7:0]      rdata,
  // fault detector pins
  input  wire logic       cathode_leak,
  // emitter drive
  output logic            drive_current_pin,
  output logic            emitter_cathode_gnd,
  output logic            laser_supply_switch_n,
  output logic            fault
);

  typedef struct packed {
    logic [7:0]         ctrl;
    ctl_state_t         st;
    logic [TIMER_W-1:0] timer;
    logic               leak_s1;
    logic               leak_s2;
    drive_out_t         drv;
  } ctl_t;

  ctl_t state;
  ctl_t next_state;
  logic pulse;
  logic laser_enabled;
  logic calibrate;

  assign laser_enabled = ~state.ctrl[HOLD_OFF_BIT];
  assign calibrate = (state.ctrl[MODE_MSB:MODE_LSB] == MODE_CALIBRATE);

  pulse_gen u_pulse
  (
    .clk    (clk),
    .arst_n (arst_n),
    .enable (laser_enabled && !calibrate && state.st == ST_RUN),
    .pulse  (pulse)
  );

  always_comb
  begin
    next_state = state;
    next_state.leak_s1 = cathode_leak;
    next_state.leak_s2 = state.leak_s1;
    // software write; fault bit is read-only status
    if (req.write && req.addr == LASER_DRIVE_CONTROL_ADDR)
    begin
      next_state.ctrl = req.wdata;
      next_state.ctrl[FAULT_BIT] = state.ctrl[FAULT_BIT];
    end
    if (state.timer != '0)
      next_state.timer = state.timer - TIMER_W'(1);
    unique case (state.st)
      ST_RUN:
      begin
        // synchroniser still holds the test ground for two cycles after the test
        if (state.leak_s2 && state.timer < TIMER_W'(SELFTEST_INTERVAL_CYC - 1))
          next_state.st = ST_FAULT;
        else if (state.timer == '0)
        begin
          next_state.st = ST_TEST;
          next_state.timer = TIMER_W'(SELFTEST_SETTLE_CYC);
        end
      end
      ST_TEST:
      begin
        // the grounded node must reach the detector before the window ends
        if (state.timer == '0)
        begin
          if (state.leak_s2)
          begin
            next_state.st = ST_RUN;
            next_state.timer = TIMER_W'(SELFTEST_INTERVAL_CYC);
          end
          else
            next_state.st = ST_FAULT;
        end
      end
      ST_FAULT:
        next_state.st = ST_FAULT;
      default:
        next_state.st = ST_FAULT;
    endcase
    // any move into the fault state also sets the sticky fault status bit on the same edge
    if (next_state.st == ST_FAULT)
      next_state.ctrl[FAULT_BIT] = 1'b1;
    next_state.drv.cathode_ground = (next_state.st == ST_TEST);
    next_state.drv.supply_switch_n = (next_state.st != ST_RUN);
    // current drops on the same edge as the switch, not one cycle later
    if (next_state.st != ST_RUN || !laser_enabled)
      next_state.drv.current_on = 1'b0;
    else if (calibrate)
      next_state.drv.current_on = 1'b1;
    else
      next_state.drv.current_on = pulse;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state.ctrl <= LASER_DRIVE_CONTROL_RST;
      state.st <= ST_RUN;
      state.timer <= TIMER_W'(SELFTEST_INTERVAL_CYC);
      state.leak_s1 <= 1'b0;
      state.leak_s2 <= 1'b0;
      state.drv <= '{current_on: 1'b0, cathode_ground: 1'b0, supply_switch_n: 1'b0};
    end
    else
      state <= next_state;
  end

  assign rdata = (req.addr == LASER_DRIVE_CONTROL_ADDR) ? state.ctrl : 8'h00;
  assign drive_current_pin = state.drv.current_on;
  assign emitter_cathode_gnd = state.drv.cathode_ground;
  assign laser_supply_switch_n = state.drv.supply_switch_n;
  assign fault = state.ctrl[FAULT_BIT];

endmodule

// *** hw/laser_pkg.sv ***
// Purpose: shared constants and types for the laser drive and fault control
// Assumes: 100 MHz core clock, register port supplied by the device's serial decoder
// Notes:   none
package laser_pkg;

  localparam logic [7:0] LASER_DRIVE_CONTROL_ADDR = 8'h20;
  localparam logic [7:0] LASER_DRIVE_CONTROL_RST  = 8'h01;
  localparam int         HOLD_OFF_BIT             = 0;
  localparam int         MODE_LSB                 = 1;
  localparam int         MODE_MSB                 = 3;
  localparam int         FAULT_BIT                = 7;
  localparam logic [2:0] MODE_CALIBRATE           = 3'h2;

  // pulsed drive timing, in ns and cycles
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PULSE_PERIOD_NS = 1000;
  localparam int PULSE_ON_NS     = 200;
  localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PULSE_ON_CYC     = (PULSE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // self-test timing
  localparam int SELFTEST_INTERVAL_NS = 40000;
  localparam int SELFTEST_SETTLE_NS   = 100;
  localparam int SELFTEST_INTERVAL_CYC = SELFTEST_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int SELFTEST_SETTLE_CYC   = (SELFTEST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 13;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic current_on;
    logic cathode_ground;
    logic supply_switch_n;
  } drive_out_t;

  typedef enum logic [1:0] {ST_RUN, ST_TEST, ST_FAULT} ctl_state_t;

endpackage

// *** hw/pulse_gen.sv ***
// Purpose: free-running pulse train for normal laser drive
// Assumes: period and on-time counts from the package
// Notes:   restarts its period while not enabled
`timescale 1ns/100ps
module pulse_gen
  import laser_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // control
  input  wire logic enable,
  output logic      pulse
);

  typedef struct packed {
    logic [TIMER_W-1:0] count;
    logic               pulse;
  } pg_state_t;

  pg_state_t state;
  pg_state_t next_state;

  always_comb
  begin
    next_state = state;
    if (!enable)
    begin
      next_state.count = '0;
      next_state.pulse = 1'b0;
    end
    else
    begin
      if (state.count == TIMER_W'(PULSE_PERIOD_CYC - 1))
        next_state.count = '0;
      else
        next_state.count = state.count + TIMER_W'(1);
      next_state.pulse = (next_state.count < TIMER_W'(PULSE_ON_CYC));
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign pulse = state.pulse;

endmodule

// *** test/emitter_model.sv ***
// Purpose: external supply switch and cathode node
// Assumes: switch conducts while its gate is low
// Notes:   shorts come from the bench
`timescale 1ns/100ps
module emitter_model
(
  // from the block
  input  wire logic laser_supply_switch_n,
  input  wire logic emitter_cathode_gnd,
  // injected shorts
  input  wire logic short_gnd,
  input  wire logic short_supply,
  // to block and bench
  output logic      supply_on,
  output logic      cathode_leak
);
  assign supply_on = !laser_supply_switch_n;
  // a supply short holds the node up, hiding the test ground
  assign cathode_leak = short_gnd || (emitter_cathode_gnd && !short_supply);
endmodule

// *** test/laser_chk.sv ***
// Purpose: port assertions for laser drive and fault control
// Assumes: one clk domain, arst_n async low
// Notes:   sees top ports only
`timescale 1ns/100ps
module laser_chk
  import laser_pkg::*;
(
  // watched ports
  input wire logic       clk,
  input wire logic       arst_n,
  input wire reg_req_t   req,
  input wire logic [7:0] rdata,
  input wire logic       cathode_leak,
  input wire logic       drive_current_pin,
  input wire logic       emitter_cathode_gnd,
  input wire logic       laser_supply_switch_n,
  input wire logic       fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire sel = req.addr == LASER_DRIVE_CONTROL_ADDR;
  a_hold: assert property ($past(sel && rdata[0]) |-> !drive_current_pin)
    else $error("drive on under hold-off");
  a_cal: assert property (!laser_supply_switch_n && $past(!laser_supply_switch_n)
    && $past(sel && rdata[3:0] == 4'h4) |-> drive_current_pin)
    else $error("calibration drive off");
  a_pulse: assert property (sel && rdata[3:1] != MODE_CALIBRATE && $rose(drive_current_pin)
    |-> ##[1:20] !drive_current_pin)
    else $error("pulse too long");
  a_fault: assert property (fault |-> laser_supply_switch_n && !drive_current_pin)
    else $error("fault outputs wrong");
  a_keep: assert property (fault |=> fault)
    else $error("fault cleared");
  a_run: assert property (!fault && !emitter_cathode_gnd |-> !laser_supply_switch_n)
    else $error("switch high in run");
  a_test: assert property (emitter_cathode_gnd |-> laser_supply_switch_n && !drive_current_pin)
    else $error("laser on during test");
  a_leak: assert property ((cathode_leak && !emitter_cathode_gnd)[*6] |-> fault)
    else $error("leak missed");
  a_stfail: assert property ((emitter_cathode_gnd && !cathode_leak)[*8] ##1
    !emitter_cathode_gnd |-> fault)
    else $error("failed test missed");
endmodule
bind laser_drive_fault_control laser_chk chk_u (.clk, .arst_n, .req, .rdata, .cathode_leak,
  .drive_current_pin, .emitter_cathode_gnd, .laser_supply_switch_n, .fault);

// *** test/tb_top.sv ***
// Purpose: self-checking bench for laser drive and fault control
// Assumes: register port rests at the control address
// Notes:   self-test interval is fixed, so the run waits for it
`timescale 1ns/100ps
module tb_top
  import laser_pkg::*;
;
  logic       clk = 0;
  logic       arst_n = 0;
  reg_req_t   req = '{1'b0, LASER_DRIVE_CONTROL_ADDR, 8'h00};
  logic       sg = 0;
  logic       ss = 0;
  logic [7:0] rdata;
  logic       leak, drv, gnd, sw_n, fault, sup;
  int         error_cnt = 0;
  int         compares = 0;
  int         n;
  logic [7:0] rows [4][2] = '{'{8'h01, 8'h01}, '{8'hF4, 8'h74}, '{8'h00, 8'h00}, '{8'h04, 8'h04}};
  wire  [7:0] pins = {4'h0, drv, sup, gnd, fault};
  always #5 clk = ~clk;
  laser_drive_fault_control dut_u (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
    .cathode_leak(leak), .drive_current_pin(drv), .emitter_cathode_gnd(gnd),
    .laser_supply_switch_n(sw_n), .fault(fault));
  emitter_model em_u (.laser_supply_switch_n(sw_n), .emitter_cathode_gnd(gnd), .short_gnd(sg),
    .short_supply(ss), .supply_on(sup), .cathode_leak(leak));
  task automatic tick(int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req = '{1'b1, a, d};
    tick();
    req = '{1'b0, LASER_DRIVE_CONTROL_ADDR, d};
    tick();
  endtask
  // bounded wait for the self-test ground to reach v
  task automatic wait_gnd(logic v);
    for (n = 0; n < 5000 && gnd !== v; n++)
      tick();
    cmp({7'h00, gnd}, {7'h00, v});
    if (gnd !== v)
      results();
  endtask
  initial
  begin
    tick(5);
    arst_n = 1;
    cmp(rdata, LASER_DRIVE_CONTROL_RST);
    cmp(pins, 8'h04);
    foreach (rows[i])
    begin
      wr(LASER_DRIVE_CONTROL_ADDR, rows[i][0]);
      cmp(rdata, rows[i][1]);
    end
    tick(2);
    cmp(pins, 8'h0C);
    wr(8'h21, 8'h00);
    req.addr = 8'h21;
    #1 cmp(rdata, 8'h00);
    tick();
    req.addr = LASER_DRIVE_CONTROL_ADDR;
    #1 cmp(rdata, 8'h04);
    $display("end of register tests");
    wr(LASER_DRIVE_CONTROL_ADDR, 8'h00);
    tick(2);
    n = 0;
    repeat (200)
    begin
      tick();
      n += drv;
    end
    cmp(8'(n), 8'h28);
    $display("end of pulse test");
    wait_gnd(1'b1);
    cmp(pins, 8'h02);
    wait_gnd(1'b0);
    tick(3);
    cmp(pins & 8'h07, 8'h04);
    $display("end of self-test pass");
    sg = 1;
    tick(8);
    cmp(pins, 8'h01);
    wr(LASER_DRIVE_CONTROL_ADDR, 8'h04);
    sg = 0;
    tick(20);
    cmp(pins, 8'h01);
    $display("end of leak fault");
    arst_n = 0;
    tick();
    arst_n = 1;
    ss = 1;
    wr(LASER_DRIVE_CONTROL_ADDR, 8'h04);
    wait_gnd(1'b1);
    wait_gnd(1'b0);
    tick();
    cmp(pins, 8'h01);
    $display("end of self-test fail");
    results();
  end
endmodule
